// ===== core/link_wd_pkg.sv
package link_wd_pkg;

    // apb register byte offsets
    localparam logic [11:0] OFS_WD_CTRL = 12'h000;
    localparam logic [11:0] OFS_LOGIC_CFG = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_INT_STATUS = 12'h00c;
    localparam logic [11:0] OFS_INT_CLEAR = 12'h010;
    localparam logic [11:0] OFS_INT_ENABLE = 12'h014;

    // field positions
    localparam int PERIOD_LSB = 0;
    localparam int ACTION_LSB = 16;
    localparam int TRIP_CLEAR_BIT = 31;
    localparam int SRC_A_LSB = 0;
    localparam int SRC_B_LSB = 4;
    localparam int OP_LSB = 8;
    localparam int NUM_EVENTS = 3;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_RESTORE = 1;
    localparam int EV_TRIP = 2;

    // reset values
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [1:0] ACTION_RST = 2'h2;
    localparam logic [3:0] SRC_RST = 4'h0;
    localparam logic [1:0] OP_RST = 2'h0;
    localparam logic [2:0] INT_EN_RST = 3'h0;

    // timing: period register counts in 10 ms units
    localparam int CLK_PERIOD_NS = 10;
    localparam int PERIOD_UNIT_MS = 10;
    localparam int TICK_CYCLES = PERIOD_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    // alarm code reported on a link trip
    localparam logic [7:0] ALARM_LINK = 8'h3c;

    // number of other flags the combiner may pick from
    localparam int NUM_FLAGS = 9;

    typedef enum logic [1:0] {
        ACT_TRIP_COAST = 2'h0,
        ACT_TRIP_STOP = 2'h1,
        ACT_DISABLED = 2'h2,
        ACT_STOP_ONLY = 2'h3
    } action_t;

    typedef enum logic [1:0] {
        OP_AND = 2'h0,
        OP_OR = 2'h1,
        OP_XOR = 2'h2,
        OP_RSVD = 2'h3
    } logic_op_t;

    typedef struct packed {
        logic [15:0] period;
        action_t action;
        logic [3:0] src_a;
        logic [3:0] src_b;
        logic_op_t op;
    } cfg_t;

    typedef struct packed {
        logic trip;
        logic stop;
        logic coast;
        logic [7:0] alarm;
    } resp_t;

endpackage

// ===== core/logic_combiner.sv
`timescale 1ns/1ps
module logic_combiner #(
    parameter int N_FLAGS = link_wd_pkg::NUM_FLAGS
) (
    input wire logic [N_FLAGS-1:0] i_flags,
    input wire logic [3:0] i_src_a,
    input wire logic [3:0] i_src_b,
    input link_wd_pkg::logic_op_t i_op,
    output logic o_result
);

    logic [15:0] padded;
    logic in_a;
    logic in_b;

    // refuse a flag count that the four-bit selects cannot serve
    if (N_FLAGS < 1 || N_FLAGS > 16) begin : g_bad_flags
        $error("logic_combiner: N_FLAGS must be 1..16");
    end

    // unused select codes read a zero input
    assign padded = {{(16-N_FLAGS){1'b0}}, i_flags};
    assign in_a = padded[i_src_a];
    assign in_b = padded[i_src_b];

    // boolean function of the two picked flags
    always_comb begin
        case (i_op)
            link_wd_pkg::OP_AND: o_result = in_a & in_b;
            link_wd_pkg::OP_OR: o_result = in_a | in_b;
            link_wd_pkg::OP_XOR: o_result = in_a ^ in_b;
            default: o_result = 1'b0;
        endcase
    end

endmodule // logic_combiner

// ===== core/link_watchdog_logic_output.sv
`timescale 1ns/1ps
module link_watchdog_logic_output #(
    parameter int TICK_CYCLES = link_wd_pkg::TICK_CYCLES
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_LINK_ACTIVITY,
    input wire logic [link_wd_pkg::NUM_FLAGS-1:0] I_OTHER_FLAGS,
    output logic O_NET_LOSS,
    output logic O_LOGIC_FLAG,
    output logic O_TRIP,
    output logic O_STOP_REQ,
    output logic O_COAST_REQ,
    output logic [7:0] O_ALARM_CODE,
    output logic O_IRQ
);

    localparam int PW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

    link_wd_pkg::cfg_t cfg_q;
    link_wd_pkg::resp_t resp_q;
    link_wd_pkg::resp_t resp_d;
    logic [PW-1:0] presc_q;
    logic [15:0] cnt_q;
    logic [16:0] cnt_next;
    logic net_loss_q;
    logic logic_flag_q;
    logic comb_result;
    logic [link_wd_pkg::NUM_EVENTS-1:0] int_st_q;
    logic [link_wd_pkg::NUM_EVENTS-1:0] int_en_q;
    logic [link_wd_pkg::NUM_EVENTS-1:0] ev_set;
    logic [link_wd_pkg::NUM_EVENTS-1:0] ev_clr;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic trip_clear;
    logic running;
    logic tick;
    logic timeout_hit;
    logic trip_mode;

    // a prescaler shorter than two cycles is refused at elaboration
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // apb decode; the slave answers in the access cycle with no wait states
    assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_en = I_PSEL & I_PENABLE & ~I_PWRITE;
    assign addr_ok = (I_PADDR == link_wd_pkg::OFS_WD_CTRL)
        || (I_PADDR == link_wd_pkg::OFS_LOGIC_CFG)
        || (I_PADDR == link_wd_pkg::OFS_STATUS)
        || (I_PADDR == link_wd_pkg::OFS_INT_STATUS)
        || (I_PADDR == link_wd_pkg::OFS_INT_CLEAR)
        || (I_PADDR == link_wd_pkg::OFS_INT_ENABLE);
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;
    assign trip_clear = wr_en && (I_PADDR == link_wd_pkg::OFS_WD_CTRL)
        && I_PWDATA[link_wd_pkg::TRIP_CLEAR_BIT];

    // configuration registers written by software
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cfg_q.period <= link_wd_pkg::PERIOD_RST;
            cfg_q.action <= link_wd_pkg::action_t'(link_wd_pkg::ACTION_RST);
            cfg_q.src_a <= link_wd_pkg::SRC_RST;
            cfg_q.src_b <= link_wd_pkg::SRC_RST;
            cfg_q.op <= link_wd_pkg::logic_op_t'(link_wd_pkg::OP_RST);
        end else if (wr_en) begin
            if (I_PADDR == link_wd_pkg::OFS_WD_CTRL) begin
                cfg_q.period <= I_PWDATA[link_wd_pkg::PERIOD_LSB +: 16];
                cfg_q.action <= link_wd_pkg::action_t'(I_PWDATA[link_wd_pkg::ACTION_LSB +: 2]);
            end
            if (I_PADDR == link_wd_pkg::OFS_LOGIC_CFG) begin
                cfg_q.src_a <= I_PWDATA[link_wd_pkg::SRC_A_LSB +: 4];
                cfg_q.src_b <= I_PWDATA[link_wd_pkg::SRC_B_LSB +: 4];
                cfg_q.op <= link_wd_pkg::logic_op_t'(I_PWDATA[link_wd_pkg::OP_LSB +: 2]);
            end
        end
    end

    // watchdog runs only with a non-zero period and no loss pending
    assign running = (cfg_q.period != 16'h0000) && !net_loss_q;
    assign tick = (presc_q == TICK_LAST);
    assign cnt_next = {1'b0, cnt_q} + 17'h00001;
    assign timeout_hit = running && tick && !I_LINK_ACTIVITY
        && (cnt_next >= {1'b0, cfg_q.period});

    // prescaler producing one tick per period unit
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            presc_q <= '0;
        end else if (I_LINK_ACTIVITY || !running || tick) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + PW'(1);
        end
    end

    // elapsed units since the last activity event
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt_q <= 16'h0000;
        end else if (I_LINK_ACTIVITY || !running) begin
            cnt_q <= 16'h0000;
        end else if (tick) begin
            cnt_q <= cnt_next[15:0];
        end
    end

    // network-loss flag, independent of the error action
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            net_loss_q <= 1'b0;
        end else if (cfg_q.period == 16'h0000) begin
            net_loss_q <= 1'b0;
        end else if (I_LINK_ACTIVITY) begin
            net_loss_q <= 1'b0;
        end else if (timeout_hit) begin
            net_loss_q <= 1'b1;
        end
    end

    // response selected by the error action
    assign trip_mode = (cfg_q.action == link_wd_pkg::ACT_TRIP_COAST)
        || (cfg_q.action == link_wd_pkg::ACT_TRIP_STOP);
    always_comb begin
        resp_d = resp_q;
        if (timeout_hit && trip_mode) begin
            resp_d.trip = 1'b1;
            resp_d.alarm = link_wd_pkg::ALARM_LINK;
            resp_d.coast = (cfg_q.action == link_wd_pkg::ACT_TRIP_COAST);
            resp_d.stop = (cfg_q.action == link_wd_pkg::ACT_TRIP_STOP);
        end else if (trip_clear) begin
            resp_d = '0;
        end else if (!resp_q.trip) begin
            resp_d.stop = (cfg_q.action == link_wd_pkg::ACT_STOP_ONLY)
                && (net_loss_q || timeout_hit);
            resp_d.coast = 1'b0;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            resp_q <= '0;
        end else begin
            resp_q <= resp_d;
        end
    end

    // boolean combiner of two other output flags
    logic_combiner #(
        .N_FLAGS(link_wd_pkg::NUM_FLAGS)
    ) u_combiner (
        .i_flags(I_OTHER_FLAGS),
        .i_src_a(cfg_q.src_a),
        .i_src_b(cfg_q.src_b),
        .i_op(cfg_q.op),
        .o_result(comb_result)
    );

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            logic_flag_q <= 1'b0;
        end else begin
            logic_flag_q <= comb_result;
        end
    end

    // interrupt events
    assign ev_set[link_wd_pkg::EV_TIMEOUT] = timeout_hit;
    assign ev_set[link_wd_pkg::EV_RESTORE] = net_loss_q && I_LINK_ACTIVITY;
    assign ev_set[link_wd_pkg::EV_TRIP] = resp_d.trip && !resp_q.trip;
    assign ev_clr = (wr_en && (I_PADDR == link_wd_pkg::OFS_INT_CLEAR))
        ? I_PWDATA[link_wd_pkg::NUM_EVENTS-1:0] : '0;

    // sticky status bits; a set in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < link_wd_pkg::NUM_EVENTS; gi++) begin : g_sticky
            always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    int_st_q[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    int_st_q[gi] <= 1'b1;
                end else if (ev_clr[gi]) begin
                    int_st_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            int_en_q <= link_wd_pkg::INT_EN_RST;
        end else if (wr_en && (I_PADDR == link_wd_pkg::OFS_INT_ENABLE)) begin
            int_en_q <= I_PWDATA[link_wd_pkg::NUM_EVENTS-1:0];
        end
    end

    // read mux; write-only and unmapped words read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (I_PADDR)
            link_wd_pkg::OFS_WD_CTRL: begin
                rdata_d[link_wd_pkg::PERIOD_LSB +: 16] = cfg_q.period;
                rdata_d[link_wd_pkg::ACTION_LSB +: 2] = cfg_q.action;
            end
            link_wd_pkg::OFS_LOGIC_CFG: begin
                rdata_d[link_wd_pkg::SRC_A_LSB +: 4] = cfg_q.src_a;
                rdata_d[link_wd_pkg::SRC_B_LSB +: 4] = cfg_q.src_b;
                rdata_d[link_wd_pkg::OP_LSB +: 2] = cfg_q.op;
            end
            link_wd_pkg::OFS_STATUS: begin
                rdata_d[2:0] = {resp_q.trip, logic_flag_q, net_loss_q};
            end
            link_wd_pkg::OFS_INT_STATUS: begin
                rdata_d[link_wd_pkg::NUM_EVENTS-1:0] = int_st_q;
            end
            link_wd_pkg::OFS_INT_ENABLE: begin
                rdata_d[link_wd_pkg::NUM_EVENTS-1:0] = int_en_q;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup cycle so it is a flop in the access cycle
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            rdata_q <= rdata_d;
        end
    end

    assign O_PRDATA = rd_en ? rdata_q : 32'h0000_0000;
    assign O_NET_LOSS = net_loss_q;
    assign O_LOGIC_FLAG = logic_flag_q;
    assign O_TRIP = resp_q.trip;
    assign O_STOP_REQ = resp_q.stop;
    assign O_COAST_REQ = resp_q.coast;
    assign O_ALARM_CODE = resp_q.alarm;
    assign O_IRQ = |(int_st_q & int_en_q);

    // checks
    logic exp_a;
    logic exp_b;
    logic exp_y;
    assign exp_a = (cfg_q.src_a < 4'h9) ? I_OTHER_FLAGS[cfg_q.src_a] : 1'b0;
    assign exp_b = (cfg_q.src_b < 4'h9) ? I_OTHER_FLAGS[cfg_q.src_b] : 1'b0;
    assign exp_y = (cfg_q.op == link_wd_pkg::OP_AND) ? (exp_a && exp_b)
        : (cfg_q.op == link_wd_pkg::OP_OR) ? (exp_a || exp_b)
        : (cfg_q.op == link_wd_pkg::OP_XOR) ? (exp_a != exp_b) : 1'b0;

    a_loss_on_timeout: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (timeout_hit && cfg_q.period == $past(cfg_q.period)) |=> O_NET_LOSS)
        else $error("loss flag missing after time-out");

    a_loss_waits_count: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $rose(O_NET_LOSS) |-> ($past(cnt_q) + 16'h0001 >= $past(cfg_q.period)))
        else $error("loss flag rose before the period elapsed");

    a_activity_clears: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_LINK_ACTIVITY |=> !O_NET_LOSS [*2])
        else $error("activity did not keep loss flag low");

    a_zero_disables: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (cfg_q.period == 16'h0000) |=> (!O_NET_LOSS && cnt_q == 16'h0000))
        else $error("watchdog active with zero period");

    a_disabled_flags: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (cfg_q.action == link_wd_pkg::ACT_DISABLED && timeout_hit)
        |=> (O_NET_LOSS && !$rose(O_TRIP)))
        else $error("disabled action broke the loss flag");

    a_trip_response: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (timeout_hit && cfg_q.action == link_wd_pkg::ACT_TRIP_COAST)
        |=> (O_TRIP && O_COAST_REQ && !O_STOP_REQ && O_ALARM_CODE == 8'h3c))
        else $error("trip-and-coast response wrong");

    a_stop_trip: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (timeout_hit && cfg_q.action == link_wd_pkg::ACT_TRIP_STOP)
        |=> (O_TRIP && O_STOP_REQ && !O_COAST_REQ))
        else $error("trip-and-stop response wrong");

    a_source_pick: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        comb_result == exp_y)
        else $error("combiner picked wrong flags or operator");

    a_flag_follows: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ##1 (O_LOGIC_FLAG == $past(exp_y)))
        else $error("combined flag does not follow the result");

    a_count_restart: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_LINK_ACTIVITY |=> (cnt_q == 16'h0000 && presc_q == '0))
        else $error("activity did not restart the count");

    a_sticky_hold: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (int_st_q[0] && !ev_clr[0]) |=> int_st_q[0])
        else $error("sticky status lost without clear");

    c_timeout: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $rose(O_NET_LOSS));
    c_restore: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $fell(O_NET_LOSS));
    c_trip: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $rose(O_TRIP));
    c_xor_high: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        cfg_q.op == link_wd_pkg::OP_XOR && O_LOGIC_FLAG);

endmodule // link_watchdog_logic_output

// ===== bench/link_master_model.sv
`timescale 1ns/1ps
// link master: one activity pulse every i_gap cycles while enabled, silent otherwise
module link_master_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic [7:0] i_gap,
    output logic o_activity
);
    logic [7:0] cnt_q;
    // spacing counter; the line stays low between bursts of traffic
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 8'h00;
            o_activity <= 1'b0;
        end else if (!i_en) begin
            cnt_q <= 8'h00;
            o_activity <= 1'b0;
        end else begin
            cnt_q <= (cnt_q + 8'h01 >= i_gap) ? 8'h00 : cnt_q + 8'h01;
            o_activity <= (cnt_q == 8'h00);
        end
    end
endmodule // link_master_model

// ===== bench/link_watchdog_logic_output_test.sv
`timescale 1ns/1ps
module link_watchdog_logic_output_test;
    localparam int TICKS = 4;
    localparam int PER = 2;
    logic clk, rst_n, psel, penable, pwrite, m_en, pready, pslverr, act, loss, lflag;
    logic trip, stop, coast, irq, err, a, b, ex;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] flags;
    logic [7:0] alarm, since_q;
    logic [1:0] ac;
    int err_total, n_compared, k, op, v;

    link_watchdog_logic_output #(.TICK_CYCLES(TICKS)) dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_LINK_ACTIVITY(act), .I_OTHER_FLAGS(flags), .O_NET_LOSS(loss),
        .O_LOGIC_FLAG(lflag), .O_TRIP(trip), .O_STOP_REQ(stop), .O_COAST_REQ(coast),
        .O_ALARM_CODE(alarm), .O_IRQ(irq));

    link_master_model master (.i_clk(clk), .i_rst_n(rst_n), .i_en(m_en),
        .i_gap(8'(PER * TICKS - 1)), .o_activity(act));

    // clock generation
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // cycles since the last activity pulse seen on the link
    always @(posedge clk) since_q <= act ? 8'h00 : (since_q == 8'hff ? since_q : since_q + 8'h01);

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic we, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input string name, input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(name, exp, rd);
        chk({name, "_err"}, 32'h0, 32'(err));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] wd(input logic [1:0] act_sel, input logic clr,
        input logic [15:0] per);
        return (32'(clr) << link_wd_pkg::TRIP_CLEAR_BIT)
            | (32'(act_sel) << link_wd_pkg::ACTION_LSB) | 32'(per);
    endfunction

    // waits a bounded time for the loss flag, then checks the silent span
    task automatic wait_loss();
        for (int i = 0; i < 40 && loss !== 1'b1; i++) cyc(1);
        chk("net_loss", 32'h1, 32'(loss));
        chk("loss_delay", 32'(PER * TICKS), 32'(since_q));
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog against a hung bench
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    // main sequence
    initial begin
        {psel, penable, pwrite, m_en, rst_n} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        flags = 9'h000;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdchk("wd_ctrl", link_wd_pkg::OFS_WD_CTRL, 32'h0002_0000);
        rdchk("logic_cfg", link_wd_pkg::OFS_LOGIC_CFG, 32'h0);
        rdchk("int_enable", link_wd_pkg::OFS_INT_ENABLE, 32'h0);
        rdchk("int_clear", link_wd_pkg::OFS_INT_CLEAR, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_rd", 32'h0, rd);
        cyc(40);
        chk("loss_off", 32'h0, 32'(loss));
        $display("test reset_and_disabled done");

        @(posedge clk) m_en <= 1'b1;
        apb(1'b1, link_wd_pkg::OFS_INT_ENABLE, 32'h7);
        apb(1'b1, link_wd_pkg::OFS_WD_CTRL, wd(2'h2, 1'b0, 16'(PER)));
        cyc(60);
        chk("loss_fed", 32'h0, 32'(loss));
        @(posedge clk) m_en <= 1'b0;
        wait_loss();
        chk("trip_off", 32'h0, 32'(trip));
        chk("alarm_off", 32'h0, 32'(alarm));
        rdchk("status", link_wd_pkg::OFS_STATUS, 32'h1);
        rdchk("int_status", link_wd_pkg::OFS_INT_STATUS, 32'h1);
        chk("irq_on", 32'h1, 32'(irq));
        $display("test timeout_flag_only done");

        for (k = 0; k < 3; k++) begin
            ac = (k == 2) ? 2'h3 : 2'(k);
            @(posedge clk) m_en <= 1'b1;
            cyc(4);
            chk("loss_restored", 32'h0, 32'(loss));
            rdchk("int_restore", link_wd_pkg::OFS_INT_STATUS, {29'h0, k != 0, 2'h3});
            apb(1'b1, link_wd_pkg::OFS_WD_CTRL, wd(ac, 1'b1, 16'(PER)));
            apb(1'b1, link_wd_pkg::OFS_INT_CLEAR, 32'h7);
            chk("irq_cleared", 32'h0, 32'(irq));
            @(posedge clk) m_en <= 1'b0;
            wait_loss();
            cyc(2);
            chk("trip", 32'(ac < 2'h2), 32'(trip));
            chk("stop", 32'(ac[0]), 32'(stop));
            chk("coast", 32'(ac == 2'h0), 32'(coast));
            chk("alarm", (ac < 2'h2) ? 32'h3c : 32'h0, 32'(alarm));
            rdchk("int_status", link_wd_pkg::OFS_INT_STATUS, {29'h0, ac < 2'h2, 2'h1});
        end
        apb(1'b1, link_wd_pkg::OFS_INT_ENABLE, 32'h0);
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1'b1, link_wd_pkg::OFS_INT_ENABLE, 32'h4);
        chk("irq_trip", 32'h0, 32'(irq));
        apb(1'b1, link_wd_pkg::OFS_INT_ENABLE, 32'h1);
        chk("irq_timeout", 32'h1, 32'(irq));
        @(posedge clk) m_en <= 1'b1;
        apb(1'b1, link_wd_pkg::OFS_WD_CTRL, wd(2'h2, 1'b1, 16'h0));
        cyc(3);
        chk("trip_cleared", 32'h0, 32'(trip));
        chk("loss_off", 32'h0, 32'(loss));
        $display("test error_actions done");

        // source a is flag 2, source b is flag 7; all other flags held high
        for (op = 0; op < 4; op++) begin
            apb(1'b1, link_wd_pkg::OFS_LOGIC_CFG, (32'(op) << link_wd_pkg::OP_LSB) | 32'h72);
            for (v = 0; v < 4; v++) begin
                a = v[1];
                b = v[0];
                @(posedge clk) flags <= 9'h17b | (9'(a) << 2) | (9'(b) << 7);
                cyc(2);
                ex = (op == 0) ? (a & b) : (op == 1) ? (a | b) : (op == 2) ? (a ^ b) : 1'b0;
                chk("logic_flag", 32'(ex), 32'(lflag));
            end
        end
        $display("test combiner done");
        complete_run();
    end
endmodule // link_watchdog_logic_output_test
